// File: include/flash_host_consts.vh
// constants for the flash command host controller
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// software register offsets (word index on the local port)
`define REG_CTRL 4'h0
`define REG_ADDR_LO 4'h1
`define REG_ADDR_HI 4'h2
`define REG_WDATA 4'h3
`define REG_RDATA 4'h4
`define REG_STAT 4'h5
`define REG_PINS 4'h6
`define REG_BUSY_TIME 4'h7
// control register fields
`define CTRL_GO_BIT 0
`define CTRL_READ_BIT 1
`define CTRL_PWRDN_BIT 2
`define CTRL_BOOTPROT_BIT 3
`define CTRL_SUPPLY_BIT 4
`define CTRL_RESET 16'h000C
// command codes
`define CMD_READ_ARRAY 16'h00FF
`define CMD_READ_ID 16'h0090
`define CMD_READ_STATUS 16'h0070
`define CMD_CLEAR_STATUS 16'h0050
`define CMD_BLOCK_ERASE 16'h0020
`define CMD_CHIP_ERASE 16'h0030
`define CMD_CONFIRM 16'h00D0
`define CMD_WORD_WRITE 16'h0040
`define CMD_WORD_WRITE_ALT 16'h0010
`define CMD_SUSPEND 16'h00B0
`define CMD_LOCK_SETUP 16'h0060
`define CMD_SET_BLOCK_LOCK 16'h0001
`define CMD_SET_PERM_LOCK 16'h00F1
`define CMD_OTP_WRITE 16'h00C0
// identifier addresses and usable otp floor
`define ID_MAKER_ADDR 20'h0_0000
`define ID_DEVICE_ADDR 20'h0_0001
`define ID_PERM_LOCK_ADDR 20'h0_0003
`define OTP_FIRST_USABLE 20'h0_0080
// status bits of the device
`define SR_READY 7
`define SR_ERASE_SUSP 6
`define SR_ERASE_ERR 5
`define SR_WRITE_ERR 4
`define SR_WRITE_SUSP 2
`define SR_PROTECT 1
// bus cycle timing in ref_clk cycles (4 ns each)
`define T_SETUP_CYC 4'd3
`define T_STROBE_CYC 4'd15
`define T_HOLD_CYC 4'd3
// least ref_clk cycles from a resume sent to the next suspend allowed out
`define T_RESUME_GAP_CYC 16'h03e8
// read mode the host believes the device to be in
`define MODE_ARRAY 2'd0
`define MODE_ID 2'd1
`define MODE_STATUS 2'd2
`endif

// File: hw/flash_host.v
// host controller that drives the flash command interface through its pins
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_consts.vh"
// Notes on behaviour
// - command FFH returns device to array read
// - 90H enters identifier and otp read
// - 70H reads status, 50H clears it
// - erase: 20H or 30H then D0H
// - word write: 40H/10H then address and data
// - B0H suspends erase or write
// - D0H resumes suspended operation
// - 60H then 01H, D0H or F1H
// - C0H then otp address/data, below 80H unusable
// - host issues only defined command codes
// - never output gate and write strobe together
module flash_host (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // software register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // flash pins
  output reg [19:0] flash_addr,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n,
  output reg flash_powerdown_n,
  output reg flash_boot_protect_n,
  output reg program_supply,
  output reg [15:0] dq_out,
  output reg dq_oe,
  input wire [15:0] dq_in,
  input wire flash_ready_busy_od
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_STROBE = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_DONE = 3'd4;

  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  reg is_read_reg;
  reg busy_reg;
  reg [15:0] ctrl_reg;
  reg [19:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg [15:0] last_cmd_reg;
  reg err_reg;
  reg [2:0] rb_sync_reg;
  reg rb_level_reg;
  // sequence guards and the host's mirror of device status
  reg [15:0] gap_cnt_reg;
  reg [1:0] read_mode_reg;
  reg [5:0] sr_flags_reg;
  reg suspended_reg;
  reg [15:0] busy_time_reg;
  reg rb_prev_reg;
  wire illegal_cmd;
  wire go;
  wire erase_setup;
  wire lock_setup;
  wire resume_cmd;
  wire bad_second;
  wire otp_low;
  wire early_suspend;
  wire refuse_cmd;
  wire go_taken;

  // only defined codes may go out as command writes; anything else is refused
  assign illegal_cmd = !(wdata_reg == `CMD_READ_ARRAY || wdata_reg == `CMD_READ_ID ||
    wdata_reg == `CMD_READ_STATUS || wdata_reg == `CMD_CLEAR_STATUS ||
    wdata_reg == `CMD_BLOCK_ERASE || wdata_reg == `CMD_CHIP_ERASE ||
    wdata_reg == `CMD_CONFIRM || wdata_reg == `CMD_WORD_WRITE ||
    wdata_reg == `CMD_WORD_WRITE_ALT || wdata_reg == `CMD_SUSPEND ||
    wdata_reg == `CMD_LOCK_SETUP || wdata_reg == `CMD_SET_BLOCK_LOCK ||
    wdata_reg == `CMD_SET_PERM_LOCK || wdata_reg == `CMD_OTP_WRITE);
  // a second-cycle data word follows a setup code and is not a command
  wire data_phase = (last_cmd_reg == `CMD_WORD_WRITE) || (last_cmd_reg == `CMD_WORD_WRITE_ALT)
    || (last_cmd_reg == `CMD_OTP_WRITE);
  assign go = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_GO_BIT] && !busy_reg;

  // a confirm code after an erase or lock setup is a second cycle, not a resume
  assign erase_setup = (last_cmd_reg == `CMD_BLOCK_ERASE) || (last_cmd_reg == `CMD_CHIP_ERASE);
  assign lock_setup = (last_cmd_reg == `CMD_LOCK_SETUP);
  assign resume_cmd = (wdata_reg == `CMD_CONFIRM) && !erase_setup && !lock_setup &&
    !data_phase;

  // an erase setup only takes a confirm, a lock setup only its three codes
  assign bad_second = (erase_setup && wdata_reg != `CMD_CONFIRM) ||
    (lock_setup && wdata_reg != `CMD_SET_BLOCK_LOCK && wdata_reg != `CMD_CONFIRM &&
    wdata_reg != `CMD_SET_PERM_LOCK);

  // otp words below the usable floor can never be programmed, so they are not sent
  assign otp_low = (last_cmd_reg == `CMD_OTP_WRITE) && (addr_reg < `OTP_FIRST_USABLE);

  // a suspend soon after a resume only stretches the erase, so it is held off
  assign early_suspend = (wdata_reg == `CMD_SUSPEND) && !data_phase &&
    (gap_cnt_reg != 16'h0000);

  // write cycles that never reach the pins; reads always go out
  assign refuse_cmd = (illegal_cmd && !data_phase) || bad_second || otp_low || early_suspend;
  assign go_taken = go && (reg_wdata[`CTRL_READ_BIT] || !refuse_cmd);

  // resume-to-suspend guard: reloads on every resume sent, counts down to zero
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_reg <= 16'h0000;
    end else if (go_taken && !reg_wdata[`CTRL_READ_BIT] && resume_cmd) begin
      gap_cnt_reg <= `T_RESUME_GAP_CYC;
    end else if (gap_cnt_reg != 16'h0000) begin
      gap_cnt_reg <= gap_cnt_reg - 16'h0001;
    end
  end

  // host's own memory of a suspend it sent; it cannot tell whether the
  // device was really busy, so a suspend sent to an idle device still sets it
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      suspended_reg <= 1'b0;
    end else if (go_taken && !reg_wdata[`CTRL_READ_BIT] && !data_phase) begin
      if (wdata_reg == `CMD_SUSPEND)
        suspended_reg <= 1'b1;
      else if (resume_cmd)
        suspended_reg <= 1'b0;
    end
  end

  // ready/busy pin is asynchronous: three stages, change counts when last two agree
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_sync_reg <= 3'b111;
      rb_level_reg <= 1'b1;
    end else begin
      rb_sync_reg <= {rb_sync_reg[1:0], flash_ready_busy_od};
      if (rb_sync_reg[2] == rb_sync_reg[1])
        rb_level_reg <= rb_sync_reg[2];
    end
  end

  // length of the last busy period on the pin, saturating; the previous-level
  // flop resets high like the idle pin so no false start follows reset
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_time_reg <= 16'h0000;
      rb_prev_reg <= 1'b1;
    end else begin
      rb_prev_reg <= rb_level_reg;
      if (rb_prev_reg && !rb_level_reg)
        busy_time_reg <= 16'h0001;
      else if (!rb_level_reg && busy_time_reg != 16'hffff)
        busy_time_reg <= busy_time_reg + 16'h0001;
    end
  end

  // software registers
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `CTRL_RESET;
      addr_reg <= 20'h0_0000;
      wdata_reg <= 16'h0000;
      err_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        ctrl_reg <= {11'h000, reg_wdata[4:2], 1'b0, reg_wdata[`CTRL_READ_BIT]};
        if (go && !reg_wdata[`CTRL_READ_BIT] && refuse_cmd)
          err_reg <= 1'b1;
      end else if (reg_addr == `REG_ADDR_LO) begin
        addr_reg[15:0] <= reg_wdata;
      end else if (reg_addr == `REG_ADDR_HI) begin
        addr_reg[19:16] <= reg_wdata[3:0];
      end else if (reg_addr == `REG_WDATA) begin
        wdata_reg <= reg_wdata;
      end else if (reg_addr == `REG_STAT) begin
        err_reg <= 1'b0;
      end
    end
  end

  // read data one cycle after the read strobe; unmapped reads return zero
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `REG_CTRL)
        reg_rdata <= ctrl_reg;
      else if (reg_addr == `REG_ADDR_LO)
        reg_rdata <= addr_reg[15:0];
      else if (reg_addr == `REG_ADDR_HI)
        reg_rdata <= {12'h000, addr_reg[19:16]};
      else if (reg_addr == `REG_WDATA)
        reg_rdata <= wdata_reg;
      else if (reg_addr == `REG_RDATA)
        reg_rdata <= rdata_reg;
      // status word: 9..4 device flags of the last status read, 3 suspend sent,
      // 2 refused command, 1 device busy from the pin, 0 bus cycle running
      else if (reg_addr == `REG_STAT)
        reg_rdata <= {6'h00, sr_flags_reg, suspended_reg, err_reg, !rb_level_reg, busy_reg};
      else if (reg_addr == `REG_PINS)
        reg_rdata <= last_cmd_reg;
      else if (reg_addr == `REG_BUSY_TIME)
        reg_rdata <= busy_time_reg;
      else
        reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // pin levels follow the control register
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_powerdown_n <= 1'b0;
      flash_boot_protect_n <= 1'b0;
      program_supply <= 1'b0;
    end else begin
      flash_powerdown_n <= ctrl_reg[`CTRL_PWRDN_BIT];
      flash_boot_protect_n <= ctrl_reg[`CTRL_BOOTPROT_BIT];
      program_supply <= ctrl_reg[`CTRL_SUPPLY_BIT];
    end
  end

  // bus cycle sequencer: setup, strobe, hold; gate and write strobe never overlap
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'd0;
      is_read_reg <= 1'b0;
      busy_reg <= 1'b0;
      flash_addr <= 20'h0_0000;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      rdata_reg <= 16'h0000;
      last_cmd_reg <= `CMD_READ_ARRAY;
      read_mode_reg <= `MODE_ARRAY;
      sr_flags_reg <= 6'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // refused codes are dropped so the device never sees them
          if (go_taken) begin
            busy_reg <= 1'b1;
            is_read_reg <= reg_wdata[`CTRL_READ_BIT];
            flash_addr <= addr_reg;
            flash_ce_n <= 1'b0;
            dq_out <= wdata_reg;
            dq_oe <= !reg_wdata[`CTRL_READ_BIT];
            cnt_reg <= `T_SETUP_CYC;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == 4'd1) begin
            flash_oe_n <= !is_read_reg;
            flash_we_n <= is_read_reg;
            cnt_reg <= `T_STROBE_CYC;
            state_reg <= ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        ST_STROBE: begin
          if (cnt_reg == 4'd1) begin
            // write strobe rises before chip select so the data latch edge is clean
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (is_read_reg) begin
              rdata_reg <= dq_in;
              // the other status bits mean nothing while the machine is busy
              if (read_mode_reg == `MODE_STATUS && dq_in[`SR_READY])
                sr_flags_reg <= {1'b1, dq_in[`SR_ERASE_SUSP], dq_in[`SR_ERASE_ERR],
                  dq_in[`SR_WRITE_ERR], dq_in[`SR_WRITE_SUSP], dq_in[`SR_PROTECT]};
              else if (read_mode_reg == `MODE_STATUS)
                sr_flags_reg <= 6'h00;
            end
            cnt_reg <= `T_HOLD_CYC;
            state_reg <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        ST_HOLD: begin
          if (cnt_reg == 4'd1) begin
            flash_ce_n <= 1'b1;
            dq_oe <= 1'b0;
            state_reg <= ST_DONE;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        ST_DONE: begin
          // a data cycle after a setup code clears the sequence memory
          if (!is_read_reg) begin
            last_cmd_reg <= data_phase ? 16'h0000 : dq_out;
            // the device reports status after any two-cycle operation
            if (data_phase || erase_setup || lock_setup) begin
              read_mode_reg <= `MODE_STATUS;
            end else begin
              case (dq_out)
                `CMD_READ_ARRAY: read_mode_reg <= `MODE_ARRAY;
                `CMD_READ_ID: read_mode_reg <= `MODE_ID;
                `CMD_READ_STATUS: read_mode_reg <= `MODE_STATUS;
                default: read_mode_reg <= read_mode_reg;
              endcase
            end
          end
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // flash_host
`default_nettype wire

// File: verif/flash_host_monitor.sv
// concurrent checks on the flash host controller pins
`timescale 1ns/100ps
`default_nettype none
module flash_host_monitor (
  // clock, reset and software port
  input wire ref_clk,
  input wire arst_n,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // flash bus
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n,
  input wire dq_oe,
  input wire [15:0] dq_out,
  input wire [19:0] flash_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // overlapping gate and strobe would let device and host fight on dq
  a_no_overlap: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("gate and strobe both low");
  a_gate_alone: assert property (!flash_oe_n |-> !dq_oe)
    else $error("host drives dq during read");
  a_strobe_in_ce: assert property ((!flash_we_n || !flash_oe_n) |-> !flash_ce_n)
    else $error("strobe outside chip select");
  a_setup_gap: assert property ($fell(flash_ce_n) |->
    (flash_we_n && flash_oe_n) [*3] ##1 (!flash_we_n || !flash_oe_n))
    else $error("setup is not three cycles");
  a_strobe_len: assert property ($fell(flash_we_n) |-> ##14 !flash_we_n ##1 flash_we_n)
    else $error("write strobe not fifteen cycles");
  a_word_stable: assert property (!flash_we_n |-> $stable(dq_out) && $stable(flash_addr))
    else $error("address or data moved under strobe");
  a_ce_hold: assert property ($rose(flash_we_n) |-> !flash_ce_n [*3] ##1 flash_ce_n)
    else $error("hold is not three cycles");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule // flash_host_monitor
`default_nettype wire

// File: verif/flash_dev_model.sv
// behavioural flash device answering the host's command cycles
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter [15:0] MAKER = 16'h1234, // arbitrary value
  parameter [15:0] PART = 16'h5678 // arbitrary value
) (
  // bus from the host
  input wire [19:0] addr,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  input wire [15:0] d,
  // protection levels
  input wire pd_n,
  input wire wp_n,
  input wire vw,
  // answers
  output wire [15:0] q,
  output wire rdy
);
  reg [7:0] sr = 8'h80;
  reg [7:0] pend = 8'h00;
  reg [1:0] md = 2'd0;
  reg lk = 1'b0;
  reg plk = 1'b0;
  reg [15:0] rdv;
  reg ers = 1'b0;
  reg run = 1'b0;
  int left = 0;
  // the write machine counts down in 4 ns steps and stands still while suspended
  always #4 if (run && !sr[7]) begin
    left = left - 4;
    if (left <= 0) begin
      run = 1'b0;
      sr[7] = 1'b1;
    end
  end
  wire prot = !pd_n || !vw;
  // one lock bit, owned by the top boot block only
  wire bad = prot || (addr >= 20'hf_f000 && lk) || (addr >= 20'hf_e000 && !wp_n);
  // undriven dq shows the inverse value, so a stale sample cannot match
  always @* begin
    case (md)
      2'd1: rdv = addr == 20'h0_0000 ? MAKER : addr == 20'h0_0001 ? PART :
        {15'h0000, addr[1:0] == 2'd3 ? plk : lk};
      2'd2: rdv = {8'h00, sr};
      default: rdv = 16'ha5a5;
    endcase
  end
  assign q = (!ce_n && !oe_n) ? rdv : ~rdv;
  assign rdy = sr[7];
  // commands land on the strobe's rising edge; suspend and resume act only while a write or erase runs
  always @(posedge we_n) if (!ce_n) begin
    if (pend == 8'h00) begin
      case (d[7:0])
        8'hff: md <= 2'd0;
        8'h90: md <= 2'd1;
        8'h70: md <= 2'd2;
        8'h50: sr <= 8'h80;
        8'hb0: if (run && !sr[7]) begin
          sr[7] <= 1'b1;
          sr[6] <= ers;
          sr[2] <= !ers;
        end
        8'hd0: if (run && sr[7]) begin
          sr[7] <= 1'b0;
          sr[6] <= 1'b0;
          sr[2] <= 1'b0;
          left <= left + 40; // every resume costs extra time
        end
        default: pend <= d[7:0];
      endcase
    end else begin
      md <= 2'd2;
      pend <= 8'h00;
      if (pend == 8'h60 && (prot || (plk && d[7:0] != 8'hf1))) sr[1] <= 1'b1;
      else if (pend == 8'h60) begin
        lk <= d[7:0] == 8'h01 ? 1'b1 : d[7:0] == 8'hd0 ? 1'b0 : lk;
        plk <= plk || d[7:0] == 8'hf1;
      end else if (pend == 8'h30 ? prot : bad) begin
        sr[1] <= 1'b1;
        sr[5:4] <= (pend == 8'h20 || pend == 8'h30) ? 2'b10 : 2'b01;
      end else begin
        sr[7] <= 1'b0;
        run <= 1'b1;
        left <= 400;
        ers <= pend == 8'h20 || pend == 8'h30;
      end
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// File: verif/test_flash_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_flash_host;
  logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, cb = 16'h000c, rv;
  wire [15:0] reg_rdata, dq_out, dq_in;
  wire [19:0] flash_addr;
  wire flash_ce_n, flash_we_n, flash_oe_n, pd_n, wp_n, vw, dq_oe, rdy;
  int err_total = 0, cmp_count = 0, cyc = 0, nce = 0, n0, i;
  // rows: command, read address, expected read word
  logic [51:0] rows [4] = '{{16'h0090, 20'h0_0000, 16'h1234}, {16'h0090, 20'h0_0001, 16'h5678},
    {16'h0070, 20'h0_0000, 16'h0080}, {16'h00ff, 20'h0_0000, 16'ha5a5}};
  flash_host i_flash_host (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_powerdown_n(pd_n), .flash_boot_protect_n(wp_n),
    .program_supply(vw), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .flash_ready_busy_od(rdy));
  flash_dev_model i_flash_dev_model (.addr(flash_addr), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .d(dq_out), .pd_n(pd_n), .wp_n(wp_n), .vw(vw), .q(dq_in), .rdy(rdy));
  initial forever #2 ref_clk = ~ref_clk;
  always @(negedge flash_ce_n) nce++;
  // hang guard: far above the fewer than two thousand cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude;
    end
  end
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
    end
  endtask
  // one flash bus cycle; r selects read, then poll busy until it drops
  task go(input [15:0] c, input [19:0] a, input r);
    begin
      wr(`REG_ADDR_LO, a[15:0]);
      wr(`REG_ADDR_HI, {12'h000, a[19:16]});
      wr(`REG_WDATA, c);
      wr(`REG_CTRL, cb | {14'h0000, r, 1'b1});
      repeat (2) @(posedge ref_clk);
      rd(`REG_STAT);
      while (rv[0] !== 1'b0) rd(`REG_STAT);
    end
  endtask
  task status(input [15:0] e);
    begin
      go(16'h0070, 20'h0_0000, 1'b0);
      go(16'h0000, 20'h0_0000, 1'b1);
      rd(`REG_RDATA);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({pd_n, wp_n, vw, flash_ce_n, dq_oe}, 5'b11010)
    for (i = 0; i < 4; i++) begin
      go(rows[i][51:36], 20'h0_0000, 1'b0);
      go(16'h0000, rows[i][35:16], 1'b1);
      rd(`REG_RDATA);
      `CHK(rv, rows[i][15:0])
    end
    $display("read modes done");
    n0 = nce;
    go(16'h0077, 20'h0_0000, 1'b0);
    rd(`REG_STAT);
    `CHK({rv[2], nce == n0}, 2'b11)
    wr(`REG_STAT, 16'h0000);
    go(16'h0040, 20'h0_0100, 1'b0);
    go(16'h1234, 20'h0_0100, 1'b0);
    status(16'h0000);
    `CHK(rv, 16'h0092)
    rd(`REG_STAT);
    `CHK(rv[9:4], 6'h25)
    go(16'h0050, 20'h0_0000, 1'b0);
    cb = 16'h0014;
    go(16'h0010, 20'hf_e000, 1'b0);
    go(16'h5555, 20'hf_e000, 1'b0);
    status(16'h0000);
    `CHK(rv, 16'h0092)
    go(16'h0050, 20'h0_0000, 1'b0);
    $display("protection done");
    cb = 16'h001c;
    go(16'h0060, 20'h0_0000, 1'b0);
    n0 = nce;
    go(16'h0020, 20'h0_0000, 1'b0);
    rd(`REG_STAT);
    `CHK({rv[2], nce == n0}, 2'b11)
    wr(`REG_STAT, 16'h0000);
    go(16'h0001, 20'hf_f000, 1'b0);
    go(16'h0020, 20'h0_0000, 1'b0);
    go(16'h00d0, 20'hf_f000, 1'b0);
    status(16'h0000);
    `CHK(rv, 16'h00a2)
    go(16'h0050, 20'h0_0000, 1'b0);
    go(16'h00c0, 20'h0_0000, 1'b0);
    n0 = nce;
    go(16'h1111, 20'h0_0040, 1'b0);
    rd(`REG_STAT);
    `CHK({rv[2], nce == n0}, 2'b11)
    wr(`REG_STAT, 16'h0000);
    go(16'h1111, 20'h0_0080, 1'b0);
    wait (rdy === 1'b1);
    repeat (4) @(posedge ref_clk);
    rd(`REG_BUSY_TIME);
    `CHK(rv >= 16'h0062 && rv <= 16'h0068, 1'b1)
    $display("lock and otp done");
    go(16'h0020, 20'h0_0000, 1'b0);
    go(16'h00d0, 20'h0_0100, 1'b0);
    `CHK(rdy, 1'b0)
    go(16'h00b0, 20'h0_0000, 1'b0);
    status(16'h0000);
    `CHK(rv, 16'h00c0)
    rd(`REG_STAT);
    `CHK({rv[9:3], rdy}, 8'hc3)
    go(16'h00d0, 20'h0_0000, 1'b0);
    `CHK(rdy, 1'b0)
    n0 = nce;
    go(16'h00b0, 20'h0_0000, 1'b0);
    rd(`REG_STAT);
    `CHK({rv[3:2], nce == n0}, 3'b011)
    wr(`REG_STAT, 16'h0000);
    wait (rdy === 1'b1);
    status(16'h0000);
    `CHK(rv, 16'h0080)
    $display("erase done");
    conclude;
  end
endmodule // test_flash_host
bind flash_host flash_host_monitor i_flash_host_monitor (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .dq_oe(dq_oe), .dq_out(dq_out), .flash_addr(flash_addr));
`default_nettype wire
